// ==== dv/stor_model.sv ====
// Purpose: Storage backend model answering the processor's commands
// Assumes: One command in flight; delays and faults set by the bench
// Notes: Answer fields carry inverted junk after each done pulse, zeros before the first
module stor_model
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Command side
   input wire logic stor_valid,
   input wire logic [31:0] stor_len,
   output logic stor_ready,
   // Answer side
   output logic stor_done,
   output logic stor_error,
   output logic [31:0] stor_xfer_bytes,
   output logic [31:0] stor_sense_bytes,
   // Bench controls
   input wire logic fail,
   input wire logic [31:0] short_by,
   input wire logic [31:0] sense_in,
   input wire logic [3:0] dly
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] len;
   // Accept after dly cycles, answer after dly more
   initial
   begin
      {stor_ready, stor_done, stor_error, stor_xfer_bytes, stor_sense_bytes} = '0;
      forever
      begin
         @(posedge pclk);
         if (presetn === 1'b1 && stor_valid === 1'b1)
         begin
            len = stor_len;
            repeat (dly) @(posedge pclk);
            stor_ready <= 1'b1;
            @(posedge pclk);
            stor_ready <= 1'b0;
            repeat (dly) @(posedge pclk);
            stor_done <= 1'b1;
            stor_error <= fail;
            stor_xfer_bytes <= len - short_by;
            stor_sense_bytes <= sense_in;
            @(posedge pclk);
            stor_done <= 1'b0;
            stor_error <= ~fail;
            stor_xfer_bytes <= ~(len - short_by);
            stor_sense_bytes <= ~sense_in;
         end
      end
   end
endmodule

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench of the block request processor
// Assumes: APB with pready, storage model on the backend
// Notes: Completion always accepted at once
`include "blk_req_params.svh"
module testbench
   import blk_req_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, req_valid = 0, fail = 0, e;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, rtype = 0, rbytes = 0, rcmd = 0, shrt = 0, sense = 0, q;
   logic [63:0] cap = 64'h0000000100000200, rsec = 0;
   logic [3:0] dly = 0;
   logic [31:0] prdata, stor_len, stor_cmd_len, xfer, sbytes, cpl_sense_len, cpl_residual;
   logic [63:0] stor_byte_addr;
   logic [7:0] cpl_status;
   logic pready, pslverr, req_ready, stor_valid, stor_ready, stor_write_through;
   logic stor_done, stor_error, cpl_valid;
   op_t stor_op;
   int mismatches = 0, checked = 0, seed = 32'hdcde, n;
   block_request_processor u_block_request_processor (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .disk_capacity_sectors(cap), .req_valid(req_valid), .req_ready(req_ready),
      .req_type(rtype), .req_sector(rsec), .req_data_bytes(rbytes), .req_cmd_bytes(rcmd),
      .stor_valid(stor_valid), .stor_ready(stor_ready), .stor_op(stor_op), .stor_byte_addr(stor_byte_addr),
      .stor_len(stor_len), .stor_cmd_len(stor_cmd_len), .stor_write_through(stor_write_through),
      .stor_done(stor_done), .stor_error(stor_error), .stor_xfer_bytes(xfer), .stor_sense_bytes(sbytes),
      .cpl_valid(cpl_valid), .cpl_ready(1'b1), .cpl_status(cpl_status), .cpl_sense_len(cpl_sense_len),
      .cpl_residual(cpl_residual));
   stor_model u_stor_model (.pclk(pclk), .presetn(presetn), .stor_valid(stor_valid), .stor_len(stor_len),
      .stor_ready(stor_ready), .stor_done(stor_done), .stor_error(stor_error), .stor_xfer_bytes(xfer),
      .stor_sense_bytes(sbytes), .fail(fail), .short_by(shrt), .sense_in(sense), .dly(dly));
   // Clock
   initial
   begin
      forever #4 pclk = ~pclk;
   end
   // Compare and count
   task check(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task give_verdict;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Sense bytes clipped to the sense area
   function automatic logic [31:0] clip(input logic [31:0] s);
      return (s > 32'h00000060) ? 32'h00000060 : s;
   endfunction
   // One APB transfer
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (n == 50)
         mismatches++;
      if (n == 50)
         give_verdict();
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // One request through to completion
   task req(input logic [31:0] t, input logic [63:0] s, input logic [31:0] b, input logic st, input op_t op,
      input logic [7:0] ex);
      logic seen;
      @(posedge pclk);
      {rtype, rsec, rbytes, req_valid} <= {t, s, b, 1'b1};
      @(posedge pclk);
      req_valid <= 1'b0;
      seen = 1'b0;
      for (n = 0; n < 200; n++)
      begin
         @(posedge pclk);
         if (stor_valid === 1'b1 && !seen)
         begin
            seen = 1'b1;
            check(stor_op, op);
            check(stor_len, op == OP_FLUSH ? 0 : b);
            check(stor_byte_addr, (op == OP_READ || op == OP_WRITE) ? s << 9 : 64'h0);
            if (op == OP_SCSI)
               check(stor_cmd_len, rcmd);
         end
         if (cpl_valid === 1'b1)
            break;
      end
      if (n == 200)
         mismatches++;
      if (n == 200)
         give_verdict();
      check(seen, st);
      check(cpl_status, ex);
      if (op == OP_SCSI)
         check({cpl_sense_len, cpl_residual}, {clip(sense), shrt});
   endtask
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `OFS_CAP_LO, 0);
      check(q, cap[31:0]);
      apb(0, `OFS_CAP_HI, 0);
      check(q, cap[63:32]);
      apb(0, 8'h80, 0);
      check(e, 1'b1);
      apb(0, `OFS_SIZE_MAX, 0);
      check(q, 0);
      apb(1, `OFS_FEAT_OFFER, 32'h000004d6);
      apb(0, `OFS_SIZE_MAX, 0);
      check(q, `RST_SIZE_MAX);
      apb(0, `OFS_CYLINDERS, 0);
      check(q, `RST_CYLINDERS);
      apb(0, `OFS_BLK_BYTES, 0);
      check(q, `RST_BLK_BYTES);
      apb(0, `OFS_MIN_IO, 0);
      check(q, `RST_MIN_IO);
      $display("test config done");
      for (int i = 0; i < 6; i++)
      begin
         dly = $random(seed);
         req(i % 2, $unsigned($random(seed)) % 1000, 512 * (i + 1), 1, i % 2 ? OP_WRITE : OP_READ, 0);
      end
      req(4, 0, 0, 1, OP_FLUSH, 0);
      req(5, 0, 0, 1, OP_FLUSH, 0);
      fail <= 1'b1;
      req(0, 3, 512, 1, OP_READ, 1);
      fail <= 1'b0;
      req(0, cap, 512, 0, OP_READ, 1);
      foreach (cap[i])
         if (i < 4)
            req(i == 3 ? 32'h80000000 : 2 + 4 * i, 0, 0, 0, OP_READ, 2);
      $display("test requests done");
      apb(1, `OFS_FEAT_NEGO, 32'h00000080);
      {shrt, rcmd} <= {32'h10, 32'hc};
      for (int t = 2; t < 4; t++)
      begin
         sense <= t == 2 ? 32'hc8 : 32'h28;
         req(t, 0, 1024, 1, OP_SCSI, 0);
      end
      apb(1, `OFS_FEAT_OFFER, 32'h00000820);
      req(1, 5, 512, 0, OP_READ, 1);
      apb(1, `OFS_CONTROL, 1);
      apb(1, `OFS_CACHE_MODE, 1);
      apb(0, `OFS_CACHE_MODE, 0);
      check({q[0], stor_write_through}, 2'b10);
      apb(1, `OFS_CACHE_MODE, 0);
      apb(0, `OFS_CACHE_MODE, 0);
      check({q[0], stor_write_through}, 2'b01);
      apb(1, `OFS_CONTROL, 3);
      apb(0, `OFS_CAP_LO, 0);
      check(q, 32'h01000000);
      $display("test packet and cache done");
      give_verdict();
   end
endmodule

// ==== hdl/blk_req_params.svh ====
// Purpose: Named offsets, field positions, codes and defaults of the block request processor
// Assumes: Included by the design module and the testbench
// Notes: Definitions only
`ifndef BLK_REQ_PARAMS_SVH
`define BLK_REQ_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets (one aligned word each)
// ----------------------------------------------------------------
`define OFS_CAP_LO      8'h00
`define OFS_CAP_HI      8'h04
`define OFS_SIZE_MAX    8'h08
`define OFS_SEG_MAX     8'h0c
`define OFS_CYLINDERS   8'h10
`define OFS_HEADS       8'h14
`define OFS_TRACK_SECT  8'h18
`define OFS_BLK_BYTES   8'h1c
`define OFS_PHYS_LOG2   8'h20
`define OFS_ALIGN_BLK   8'h24
`define OFS_MIN_IO      8'h28
`define OFS_OPT_IO      8'h2c
`define OFS_CACHE_MODE  8'h30
`define OFS_FEAT_OFFER  8'h34
`define OFS_FEAT_NEGO   8'h38
`define OFS_CONTROL     8'h3c
`define OFS_STATUS      8'h40

// ----------------------------------------------------------------
// Feature bit positions
// ----------------------------------------------------------------
`define FEAT_BARRIER      0
`define FEAT_SIZE_MAX     1
`define FEAT_SEG_MAX      2
`define FEAT_GEOMETRY     4
`define FEAT_READ_ONLY    5
`define FEAT_BLK_SIZE     6
`define FEAT_SCSI         7
`define FEAT_FLUSH        9
`define FEAT_TOPOLOGY     10
`define FEAT_CACHE_SWITCH 11

// ----------------------------------------------------------------
// Request type codes, status codes, units
// ----------------------------------------------------------------
`define TYPE_READ       31'h00000000
`define TYPE_WRITE      31'h00000001
`define TYPE_SCSI_A     31'h00000002
`define TYPE_SCSI_B     31'h00000003
`define TYPE_FLUSH_A    31'h00000004
`define TYPE_FLUSH_B    31'h00000005
`define TYPE_BARRIER_BIT 31
`define STATUS_OK       8'h00
`define STATUS_IO_ERR   8'h01
`define STATUS_UNSUPP   8'h02
`define SECTOR_SHIFT    9
`define SENSE_BYTES_MAX 32'h00000060
`define CACHE_WRITETHROUGH 1'b0
`define CACHE_WRITEBACK    1'b1

// ----------------------------------------------------------------
// Reset values of configuration fields
// ----------------------------------------------------------------
`define RST_FEAT_OFFER  32'h00000000
`define RST_FEAT_NEGO   32'h00000000
`define RST_SIZE_MAX    32'h00010000
`define RST_SEG_MAX     32'h00000080
`define RST_CYLINDERS   16'h0400
`define RST_HEADS       8'h10
`define RST_TRACK_SECT  8'h3f
`define RST_BLK_BYTES   32'h00000200
`define RST_PHYS_LOG2   8'h00
`define RST_ALIGN_BLK   8'h00
`define RST_MIN_IO      16'h0001
`define RST_OPT_IO      32'h00000000

`endif

// ==== hdl/blk_req_pkg.sv ====
// Purpose: Types of the block request processor
// Assumes: Nothing beyond the standard language
// Notes: Numbers live in blk_req_params.svh
package blk_req_pkg;

   // Storage operation handed to the backend
   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_FLUSH, OP_SCSI} op_t;

   // Request engine states
   typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT, S_DONE} state_t;

endpackage

// ==== hdl/block_request_processor.sv ====
// Purpose: Request queue processor and configuration space of a virtual disk
// Assumes: Requests arrive one at a time from queue logic on pclk; backend answers on pclk
// Notes: One request is in flight at a time, so completions keep submission order
`include "blk_req_params.svh"

// Functional notes
// - Capacity in 512-byte sectors is always readable as a 64-bit value.
// - Bits 1, 2, 4 validate segment size, segment count and geometry fields.
// - With read-only offered, every write request fails.
// - Bit 6 validates the preferred block size, a performance hint only.
// - Bit 10 validates the topology fields.
// - Request sector quantities are always 512-byte units.
// - Type 0 reads, type 1 writes, type 4 flushes.
// - Type 5 behaves exactly like type 4.
// - Read/write byte position is sector times 512; flush and packet ignore sector.
// - Completion writes status 0 ok, 1 I/O error, 2 unsupported.
// - Flush commits every earlier completed write to non-volatile storage.
// - Completion order is free except around barriers and flushes.
// - Legacy cache switch byte: 0 writethrough, 1 writeback, reads current mode.
// - Without switch, mode follows negotiated flush bit 9.
// - Barrier bit waits for earlier requests and holds later ones back.
// - With bit 7, types 2 and 3 are identical packet commands.
// - Packet command length comes from its own buffer length.
// - Transfer size comes from the total data buffer size.
// - Packet requests report sense bytes written, at most 96.
// - Packet residual is requested length minus bytes transferred.
// - Fields little-endian; legacy mode uses guest native order.
module block_request_processor
   import blk_req_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Backend disk size
   input wire logic [63:0] disk_capacity_sectors,
   // Request from the queue
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [31:0] req_type,
   input wire logic [63:0] req_sector,
   input wire logic [31:0] req_data_bytes,
   input wire logic [31:0] req_cmd_bytes,
   // Storage backend command
   output logic stor_valid,
   input wire logic stor_ready,
   output op_t stor_op,
   output logic [63:0] stor_byte_addr,
   output logic [31:0] stor_len,
   output logic [31:0] stor_cmd_len,
   output logic stor_write_through,
   // Storage backend answer
   input wire logic stor_done,
   input wire logic stor_error,
   input wire logic [31:0] stor_xfer_bytes,
   input wire logic [31:0] stor_sense_bytes,
   // Completion to the queue
   output logic cpl_valid,
   input wire logic cpl_ready,
   output logic [7:0] cpl_status,
   output logic [31:0] cpl_sense_len,
   output logic [31:0] cpl_residual
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [31:0] feat_offer_reg;
   logic [31:0] feat_nego_reg;
   logic legacy_mode_reg;
   logic guest_big_endian_reg;
   logic cache_mode_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;
   logic [31:0] rd_word;
   logic rd_hit;
   logic [63:0] field_val;
   logic [63:0] field_ord;
   logic [3:0] field_bytes;
   logic setup_phase;
   logic wr_access;
   state_t state_reg;
   state_t state_next;
   op_t op_reg;
   logic [63:0] addr_reg;
   logic [31:0] len_reg;
   logic [31:0] cmd_len_reg;
   logic [7:0] status_reg;
   logic [31:0] sense_len_reg;
   logic [31:0] residual_reg;
   logic [15:0] done_count_reg;
   logic accept;
   logic [30:0] type_code;
   logic barrier_ok;
   logic is_read;
   logic is_write;
   logic is_flush;
   logic is_scsi;
   logic [64:0] req_end;
   logic out_of_range;
   logic feat_read_only;
   logic feat_cache_mode_switch;
   logic [7:0] status_io_error;
   logic [7:0] status_unsupported;

   assign feat_read_only = feat_offer_reg[`FEAT_READ_ONLY];
   assign feat_cache_mode_switch = feat_offer_reg[`FEAT_CACHE_SWITCH];
   assign status_io_error = `STATUS_IO_ERR;
   assign status_unsupported = `STATUS_UNSUPP;

   // ----------------------------------------------------------------
   // Byte order of one configuration field
   // ----------------------------------------------------------------
   function automatic logic [63:0] field_order(input logic [63:0] v, input logic [3:0] nbytes,
                                                input logic swap);
      logic [63:0] r;
      r = v;
      if (swap)
      begin
         r = 64'h0;
         for (int i = 0; i < 8; i++)
         begin
            if (i < int'(nbytes))
            begin
               r[8*i +: 8] = v[8*(int'(nbytes) - 1 - i) +: 8];
            end
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // APB access decode
   // ----------------------------------------------------------------
   assign setup_phase = psel && !penable;
   assign wr_access = psel && penable && pwrite && !pslverr_reg;
   assign pready = 1'b1;
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;

   // Field value, width and word select for reads
   always_comb
   begin
      field_val = 64'h0;
      field_bytes = 4'h4;
      rd_hit = 1'b1;
      case (paddr)
         `OFS_CAP_LO, `OFS_CAP_HI:
         begin
            field_val = disk_capacity_sectors;
            field_bytes = 4'h8;
         end
         `OFS_SIZE_MAX: field_val = feat_offer_reg[`FEAT_SIZE_MAX] ? {32'h0, `RST_SIZE_MAX} : 64'h0;
         `OFS_SEG_MAX: field_val = feat_offer_reg[`FEAT_SEG_MAX] ? {32'h0, `RST_SEG_MAX} : 64'h0;
         `OFS_CYLINDERS:
         begin
            field_val = feat_offer_reg[`FEAT_GEOMETRY] ? {48'h0, `RST_CYLINDERS} : 64'h0;
            field_bytes = 4'h2;
         end
         `OFS_HEADS:
         begin
            field_val = feat_offer_reg[`FEAT_GEOMETRY] ? {56'h0, `RST_HEADS} : 64'h0;
            field_bytes = 4'h1;
         end
         `OFS_TRACK_SECT:
         begin
            field_val = feat_offer_reg[`FEAT_GEOMETRY] ? {56'h0, `RST_TRACK_SECT} : 64'h0;
            field_bytes = 4'h1;
         end
         `OFS_BLK_BYTES: field_val = feat_offer_reg[`FEAT_BLK_SIZE] ? {32'h0, `RST_BLK_BYTES} : 64'h0;
         `OFS_PHYS_LOG2:
         begin
            field_val = feat_offer_reg[`FEAT_TOPOLOGY] ? {56'h0, `RST_PHYS_LOG2} : 64'h0;
            field_bytes = 4'h1;
         end
         `OFS_ALIGN_BLK:
         begin
            field_val = feat_offer_reg[`FEAT_TOPOLOGY] ? {56'h0, `RST_ALIGN_BLK} : 64'h0;
            field_bytes = 4'h1;
         end
         `OFS_MIN_IO:
         begin
            field_val = feat_offer_reg[`FEAT_TOPOLOGY] ? {48'h0, `RST_MIN_IO} : 64'h0;
            field_bytes = 4'h2;
         end
         `OFS_OPT_IO: field_val = feat_offer_reg[`FEAT_TOPOLOGY] ? {32'h0, `RST_OPT_IO} : 64'h0;
         `OFS_CACHE_MODE:
         begin
            field_val = {63'h0, cache_mode_reg};
            field_bytes = 4'h1;
         end
         `OFS_FEAT_OFFER: field_val = {32'h0, feat_offer_reg};
         `OFS_FEAT_NEGO: field_val = {32'h0, feat_nego_reg};
         `OFS_CONTROL: field_val = {62'h0, guest_big_endian_reg, legacy_mode_reg};
         `OFS_STATUS: field_val = {32'h0, done_count_reg, status_reg, 4'h0, 1'b0, 1'(state_reg != S_IDLE),
                                   2'(state_reg)};
         default: rd_hit = 1'b0;
      endcase
   end

   // Legacy guests see their native byte order when big-endian
   assign field_ord = field_order(field_val, field_bytes, legacy_mode_reg && guest_big_endian_reg);
   assign rd_word = (paddr == `OFS_CAP_HI) ? field_ord[63:32] : field_ord[31:0];

   // Read data and error captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_reg <= 32'h0;
         pslverr_reg <= 1'b0;
      end
      else if (setup_phase)
      begin
         prdata_reg <= pwrite ? 32'h0 : rd_word;
         pslverr_reg <= !rd_hit;
      end
   end

   // ----------------------------------------------------------------
   // Writable registers
   // ----------------------------------------------------------------
   // Features, legacy control
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         feat_offer_reg <= `RST_FEAT_OFFER;
         feat_nego_reg <= `RST_FEAT_NEGO;
         legacy_mode_reg <= 1'b0;
         guest_big_endian_reg <= 1'b0;
      end
      else if (wr_access)
      begin
         if (paddr == `OFS_FEAT_OFFER)
         begin
            feat_offer_reg <= pwdata;
         end
         if (paddr == `OFS_FEAT_NEGO)
         begin
            feat_nego_reg <= pwdata & feat_offer_reg;
         end
         if (paddr == `OFS_CONTROL)
         begin
            legacy_mode_reg <= pwdata[0];
            guest_big_endian_reg <= pwdata[1];
         end
      end
   end

   // Cache mode: software switch or follows negotiated flush
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cache_mode_reg <= `CACHE_WRITETHROUGH;
      end
      else if (wr_access && paddr == `OFS_CACHE_MODE && legacy_mode_reg && feat_cache_mode_switch)
      begin
         cache_mode_reg <= pwdata[0];
      end
      else if (wr_access && paddr == `OFS_FEAT_NEGO && !feat_cache_mode_switch)
      begin
         cache_mode_reg <= pwdata[`FEAT_FLUSH] & feat_offer_reg[`FEAT_FLUSH];
      end
   end

   // ----------------------------------------------------------------
   // Request decode
   // ----------------------------------------------------------------
   assign accept = req_valid && req_ready;
   assign type_code = req_type[30:0];
   assign barrier_ok = !req_type[`TYPE_BARRIER_BIT] || feat_nego_reg[`FEAT_BARRIER];
   assign is_read = barrier_ok && type_code == `TYPE_READ;
   assign is_write = barrier_ok && type_code == `TYPE_WRITE;
   assign is_flush = barrier_ok && (type_code == `TYPE_FLUSH_A || type_code == `TYPE_FLUSH_B);
   assign is_scsi = barrier_ok && feat_nego_reg[`FEAT_SCSI]
                    && (type_code == `TYPE_SCSI_A || type_code == `TYPE_SCSI_B);
   // End sector from the data size in 512-byte units
   assign req_end = {1'b0, req_sector} + {42'h0, req_data_bytes[31:`SECTOR_SHIFT]};
   assign out_of_range = req_end > {1'b0, disk_capacity_sectors};

   // ----------------------------------------------------------------
   // Request engine
   // ----------------------------------------------------------------
   // Only one request in flight, so a barrier finds all earlier ones done
   assign req_ready = state_reg == S_IDLE;
   assign stor_valid = state_reg == S_ISSUE;
   assign cpl_valid = state_reg == S_DONE;

   // Next state
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE:
         begin
            if (accept)
            begin
               if ((is_read || is_flush || is_scsi) || (is_write && !feat_read_only))
               begin
                  state_next = ((is_read || is_write) && out_of_range) ? S_DONE : S_ISSUE;
               end
               else
               begin
                  state_next = S_DONE;
               end
            end
         end
         S_ISSUE:
         begin
            if (stor_ready)
            begin
               state_next = S_WAIT;
            end
         end
         S_WAIT:
         begin
            if (stor_done)
            begin
               state_next = S_DONE;
            end
         end
         S_DONE:
         begin
            if (cpl_ready)
            begin
               state_next = S_IDLE;
            end
         end
         default: state_next = S_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= S_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Storage command captured at acceptance
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         op_reg <= OP_READ;
         addr_reg <= 64'h0;
         len_reg <= 32'h0;
         cmd_len_reg <= 32'h0;
      end
      else if (accept)
      begin
         op_reg <= is_flush ? OP_FLUSH : is_scsi ? OP_SCSI : is_write ? OP_WRITE : OP_READ;
         // Sector ignored for flush and packet commands
         addr_reg <= (is_read || is_write) ? {req_sector[63-`SECTOR_SHIFT:0], `SECTOR_SHIFT'(0)} : 64'h0;
         len_reg <= is_flush ? 32'h0 : req_data_bytes;
         cmd_len_reg <= is_scsi ? req_cmd_bytes : 32'h0;
      end
   end

   assign stor_op = op_reg;
   assign stor_byte_addr = addr_reg;
   assign stor_len = len_reg;
   assign stor_cmd_len = cmd_len_reg;
   assign stor_write_through = cache_mode_reg == `CACHE_WRITETHROUGH;

   // Completion status, sense length and residual
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status_reg <= `STATUS_OK;
         sense_len_reg <= 32'h0;
         residual_reg <= 32'h0;
      end
      else if (accept)
      begin
         sense_len_reg <= 32'h0;
         residual_reg <= 32'h0;
         if (!(is_read || is_write || is_flush || is_scsi))
         begin
            status_reg <= status_unsupported;
         end
         else if ((is_write && feat_read_only) || ((is_read || is_write) && out_of_range))
         begin
            status_reg <= status_io_error;
         end
         else
         begin
            status_reg <= `STATUS_OK;
         end
      end
      else if (state_reg == S_WAIT && stor_done)
      begin
         status_reg <= stor_error ? status_io_error : `STATUS_OK;
         if (op_reg == OP_SCSI)
         begin
            sense_len_reg <= (stor_sense_bytes > `SENSE_BYTES_MAX) ? `SENSE_BYTES_MAX : stor_sense_bytes;
            residual_reg <= len_reg - stor_xfer_bytes;
         end
      end
   end

   assign cpl_status = status_reg;
   assign cpl_sense_len = sense_len_reg;
   assign cpl_residual = residual_reg;

   // Completed request counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         done_count_reg <= 16'h0;
      end
      else if (cpl_valid && cpl_ready)
      begin
         done_count_reg <= done_count_reg + 16'h1;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   ro_write_fail_a: assert property (
      accept && is_write && feat_read_only |=> cpl_valid && cpl_status == `STATUS_IO_ERR && !stor_valid)
      else $error("write on read-only disk not failed");

   unknown_type_a: assert property (
      accept && !(is_read || is_write || is_flush || is_scsi) |=> cpl_valid && cpl_status == `STATUS_UNSUPP)
      else $error("unknown type not completed as unsupported");

   flush_alias_a: assert property (
      accept && barrier_ok && type_code == `TYPE_FLUSH_B |=> stor_valid && stor_op == OP_FLUSH
                                                             && stor_byte_addr == 64'h0)
      else $error("second flush code not handled as flush");

   byte_pos_a: assert property (
      accept && is_read && !out_of_range |=> stor_valid
         && stor_byte_addr == {$past(req_sector[63-`SECTOR_SHIFT:0]), `SECTOR_SHIFT'(0)})
      else $error("read byte position not sector times 512");

   packet_cmd_a: assert property (
      accept && is_scsi |=> stor_op == OP_SCSI && stor_cmd_len == $past(req_cmd_bytes))
      else $error("packet command not issued with its length");

   sense_cap_a: assert property (
      cpl_valid |-> cpl_sense_len <= `SENSE_BYTES_MAX)
      else $error("sense length beyond 96 bytes");

   residual_calc_a: assert property (
      state_reg == S_WAIT && stor_done && op_reg == OP_SCSI
      |=> cpl_residual == $past(len_reg) - $past(stor_xfer_bytes))
      else $error("residual not requested minus transferred");

   one_flight_a: assert property (
      stor_valid || state_reg == S_WAIT |-> !req_ready)
      else $error("request accepted while another is in flight");

   mode_follow_a: assert property (
      wr_access && paddr == `OFS_FEAT_NEGO && !feat_cache_mode_switch
      |=> cache_mode_reg == ($past(pwdata[`FEAT_FLUSH]) && $past(feat_offer_reg[`FEAT_FLUSH])))
      else $error("cache mode does not follow negotiated flush");

   cap_read_a: assert property (
      setup_phase && !pwrite && paddr == `OFS_CAP_LO && !legacy_mode_reg
      |=> prdata == $past(disk_capacity_sectors[31:0]))
      else $error("capacity low word wrong");

   gate_read_a: assert property (
      setup_phase && !pwrite && paddr == `OFS_SIZE_MAX && !feat_offer_reg[`FEAT_SIZE_MAX] |=> prdata == 32'h0)
      else $error("segment size limit visible without its feature");

   read_done_c: cover property (accept && is_read ##[1:20] cpl_valid && cpl_status == `STATUS_OK);
   scsi_done_c: cover property (accept && is_scsi ##[1:20] cpl_valid);
   mode_switch_c: cover property (wr_access && paddr == `OFS_CACHE_MODE && legacy_mode_reg && feat_cache_mode_switch);

endmodule
